// File: inc/usm_pkg.sv
// package for the serial mode control block: register map and fields
package usm_pkg;
  localparam logic [11:0] ADDR_CONTROL   = 12'h030;
  localparam logic [11:0] ADDR_HALF_DUP  = 12'h034;
  localparam logic [11:0] ADDR_CARD_CTRL = 12'h038;
  localparam logic [11:0] ADDR_MULTIDROP = 12'h03c;
  localparam logic [11:0] ADDR_MATCH     = 12'h040;
  localparam logic [11:0] ADDR_DELAY     = 12'h044;
  localparam logic [11:0] ADDR_STATUS    = 12'h04c;
  localparam logic [2:0]  MODE_UART      = 3'h0;
  localparam logic [2:0]  MODE_MODEM     = 3'h1;
  localparam logic [2:0]  MODE_CARD      = 3'h3;
  localparam logic [2:0]  MODE_SYNC      = 3'h4;
  localparam logic [2:0]  MODE_RS485     = 3'h5;
  localparam logic [7:0]  GUARD_ONE_BIT  = 8'hff;
  localparam logic [9:0]  NOMINAL_GUARD  = 10'h002;
  localparam logic [31:0] CONTROL_RESET  = 32'h000000c0;
  // status bits
  localparam int ST_TX_ERROR  = 0;
  localparam int ST_PARITY    = 1;
  localparam int ST_ADDR_SEEN = 2;
  localparam int ST_RX_LOCKED = 3;
  typedef enum logic [1:0] {
    USM_TX_IDLE, USM_TX_SHIFT, USM_TX_GUARD, USM_TX_HOLD
  } usm_tx_state_type;
endpackage

// File: rtl/usm_core.sv
// serial mode control: pin assignment, half duplex, card and rs-485 control
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module usm_core
  import usm_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial engine events
  input  wire logic        bit_tick,
  input  wire logic        tx_start,
  input  wire logic        tx_last_bit,
  input  wire logic        tx_pending,
  input  wire logic        rx_busy,
  input  wire logic        rx_char_done,
  input  wire logic [8:0]  rx_char,
  input  wire logic        rx_char_bad,
  input  wire logic        nack_seen,
  input  wire logic        fifo_clear,
  // pins
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_route,
  output logic             serial_rx_route,
  output logic             direction_route,
  output logic             direction_pin,
  output logic             card_clock_route,
  output logic             card_clock_pin,
  // to the serial engine
  output logic             rx_gated_data,
  output logic             rx_accept,
  output logic             tx_lock,
  output logic             tx_retry,
  output logic             nack_send,
  output logic             parity_irq
);
  logic [31:0] control_q, card_q;
  logic        half_q;
  logic [5:0]  multidrop_q;
  logic [7:0]  match_q, delay_q;
  logic        tx_err_q, parity_q, addr_seen_q, rx_lock_q;
  logic        rx_s1_q, rx_s2_q;
  logic [7:0]  clk_cnt_q, dly_cnt_q;
  logic [9:0]  guard_cnt_q;
  logic [2:0]  retry_cnt_q;
  logic        dir_active_q;
  usm_tx_state_type tx_state_q;

  logic wr_en, unit_on, t0_mode, nmm_on, aad_on, card_mode, rs485;
  logic [2:0] mode;
  assign wr_en     = psel & penable & pwrite;
  assign unit_on   = control_q[0];
  assign mode      = control_q[3:1];
  assign card_mode = unit_on && (mode == MODE_CARD);
  assign rs485     = unit_on && (mode == MODE_RS485);
  assign t0_mode   = card_mode && !card_q[2];
  assign nmm_on    = multidrop_q[0];
  assign aad_on    = multidrop_q[2];

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == ADDR_CONTROL) || (a == ADDR_HALF_DUP) ||
                 (a == ADDR_CARD_CTRL) || (a == ADDR_MULTIDROP) ||
                 (a == ADDR_MATCH) || (a == ADDR_DELAY) ||
                 (a == ADDR_STATUS);
  endfunction

  // register writes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      control_q   <= CONTROL_RESET;
      half_q      <= 1'b0;
      card_q      <= 32'h00000000;
      multidrop_q <= 6'h00;
      match_q     <= 8'h00;
      delay_q     <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CONTROL:   control_q <= {24'h000000, pwdata[7:6], 2'h0,
                                      pwdata[3:0]};
        ADDR_HALF_DUP:  half_q <= pwdata[0];
        ADDR_CARD_CTRL: card_q <= {8'h00, pwdata[23:5], 1'b0,
                                   pwdata[3:1], 1'b0};
        ADDR_MULTIDROP: multidrop_q <= {pwdata[5:4], 1'b0, pwdata[2:0]};
        ADDR_MATCH:     match_q <= pwdata[7:0];
        ADDR_DELAY:     delay_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // apb read and answer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known_addr(paddr);
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_CONTROL:   prdata <= control_q;
          ADDR_HALF_DUP:  prdata <= {31'h00000000, half_q};
          ADDR_CARD_CTRL: prdata <= card_q;
          ADDR_MULTIDROP: prdata <= {26'h0000000, multidrop_q};
          ADDR_MATCH:     prdata <= {24'h000000, match_q};
          ADDR_DELAY:     prdata <= {24'h000000, delay_q};
          ADDR_STATUS:    prdata <= {28'h0000000, rx_lock_q, addr_seen_q,
                                     parity_q, tx_err_q};
          default:        prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // receive pin synchroniser
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= serial_rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  logic tx_shifting;
  assign tx_shifting = (tx_state_q == USM_TX_SHIFT);

  // half-duplex receive lock and line gating
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_lock_q     <= 1'b0;
      rx_gated_data <= 1'b1;
    end else begin
      if (!half_q || card_mode)
        rx_lock_q <= 1'b0;
      else if (tx_pending && (!rx_busy || rx_char_done))
        rx_lock_q <= 1'b1;
      else if (!tx_pending && !tx_shifting)
        rx_lock_q <= 1'b0;
      // own transmission is not echoed into the receiver
      rx_gated_data <= (half_q && tx_shifting) ? 1'b1 : rx_s2_q;
    end
  end

  // pin routing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      serial_tx_route  <= 1'b0;
      serial_rx_route  <= 1'b0;
      direction_route  <= 1'b0;
      card_clock_route <= 1'b0;
    end else begin
      serial_tx_route  <= unit_on;
      serial_rx_route  <= unit_on && (mode != MODE_CARD);
      direction_route  <= (rs485 && multidrop_q[4]) ||
                          (unit_on && mode == MODE_MODEM);
      card_clock_route <= card_mode && card_q[3];
    end
  end

  // card clock divider
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clk_cnt_q      <= 8'h00;
      card_clock_pin <= 1'b0;
    end else if (!(card_mode && card_q[3])) begin
      clk_cnt_q      <= 8'h00;
      card_clock_pin <= 1'b0;
    end else if (clk_cnt_q == card_q[23:16]) begin
      clk_cnt_q      <= 8'h00;
      card_clock_pin <= ~card_clock_pin;
    end else begin
      clk_cnt_q <= clk_cnt_q + 8'h01;
    end
  end

  // card transmit sequencing: guard time, nack retries, lock
  logic [9:0] guard_len;
  assign guard_len = (card_q[15:8] == GUARD_ONE_BIT) ? 10'h001 :
                     NOMINAL_GUARD + {2'b00, card_q[15:8]};
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_q  <= USM_TX_IDLE;
      guard_cnt_q <= 10'h000;
      retry_cnt_q <= 3'h0;
      tx_err_q    <= 1'b0;
      tx_retry    <= 1'b0;
    end else begin
      tx_retry <= 1'b0;
      if (fifo_clear) begin
        retry_cnt_q <= 3'h0;
        tx_err_q    <= 1'b0;
      end
      case (tx_state_q)
        USM_TX_IDLE: if (tx_start) tx_state_q <= USM_TX_SHIFT;
        USM_TX_SHIFT: if (tx_last_bit) begin
          guard_cnt_q <= t0_mode ? guard_len : 10'h001;
          tx_state_q  <= USM_TX_GUARD;
        end
        USM_TX_GUARD: begin
          if (t0_mode && nack_seen) begin
            if (retry_cnt_q == card_q[7:5]) begin
              tx_err_q   <= 1'b1;
              tx_state_q <= USM_TX_HOLD;
            end else begin
              retry_cnt_q <= retry_cnt_q + 3'h1;
              tx_retry    <= 1'b1;
              tx_state_q  <= USM_TX_IDLE;
            end
          end else if (bit_tick) begin
            if (guard_cnt_q <= 10'h001) begin
              tx_state_q  <= USM_TX_IDLE;
              retry_cnt_q <= 3'h0;
            end else begin
              guard_cnt_q <= guard_cnt_q - 10'h001;
            end
          end
        end
        USM_TX_HOLD: if (fifo_clear) tx_state_q <= USM_TX_IDLE;
        default: tx_state_q <= USM_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_lock   <= 1'b0;
      nack_send <= 1'b0;
    end else begin
      tx_lock   <= (tx_state_q == USM_TX_HOLD) || rx_lock_q;
      nack_send <= t0_mode && rx_char_done && rx_char_bad &&
                   !card_q[1];
    end
  end

  // multidrop receive filter
  logic is_addr, rx_ok;
  assign is_addr = rx_char[8];
  assign rx_ok   = !nmm_on || multidrop_q[1];
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      parity_q    <= 1'b0;
      addr_seen_q <= 1'b0;
      rx_accept   <= 1'b0;
      parity_irq  <= 1'b0;
    end else begin
      rx_accept  <= 1'b0;
      parity_irq <= 1'b0;
      if (wr_en && paddr == ADDR_STATUS && pwdata[ST_PARITY])
        parity_q <= 1'b0;
      if (rx_char_done && rx_ok) begin
        if (nmm_on && is_addr) begin
          parity_q   <= 1'b1;
          parity_irq <= 1'b1;
          if (aad_on)
            addr_seen_q <= (rx_char[7:0] == match_q);
          else
            rx_accept <= 1'b1;
        end else begin
          rx_accept <= !(nmm_on && aad_on) || addr_seen_q;
        end
      end
      if (!nmm_on || !aad_on)
        addr_seen_q <= 1'b0;
    end
  end

  // rs-485 direction control with turnaround delay
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dir_active_q  <= 1'b0;
      dly_cnt_q     <= 8'h00;
      direction_pin <= 1'b1;
    end else begin
      if (tx_pending || tx_shifting) begin
        dir_active_q <= 1'b1;
        dly_cnt_q    <= delay_q;
      end else if (dir_active_q) begin
        if (dly_cnt_q == 8'h00)
          dir_active_q <= 1'b0;
        else if (bit_tick)
          dly_cnt_q <= dly_cnt_q - 8'h01;
      end
      direction_pin <= dir_active_q ^ ~multidrop_q[5];
    end
  end

  a_card_clk_off: assert property (@(posedge mclk)
    disable iff (!rst_b) !(card_mode && card_q[3]) |=> !card_clock_pin)
    else $error("card clock runs while disabled");
  a_nack_suppress: assert property (@(posedge mclk)
    disable iff (!rst_b)
    (rx_char_done && rx_char_bad && t0_mode && card_q[1]) |=> !nack_send)
    else $error("nack sent while suppressed");
  a_nack_given: assert property (@(posedge mclk)
    disable iff (!rst_b)
    (rx_char_done && rx_char_bad && t0_mode && !card_q[1]) |=> nack_send)
    else $error("nack missing");
  a_rx_gate_nmm: assert property (@(posedge mclk)
    disable iff (!rst_b) (rx_char_done && nmm_on && !multidrop_q[1])
    |=> !rx_accept && !parity_irq)
    else $error("reception not gated");
  a_addr_parity: assert property (@(posedge mclk)
    disable iff (!rst_b)
    (rx_char_done && nmm_on && multidrop_q[1] && is_addr) |=> parity_q)
    else $error("address not flagged");
  a_pins_gpio: assert property (@(posedge mclk)
    disable iff (!rst_b)
    !unit_on |=> !serial_tx_route && !serial_rx_route && !card_clock_route)
    else $error("pins routed while unit off");
  a_error_hold: assert property (@(posedge mclk)
    disable iff (!rst_b) (tx_state_q == USM_TX_HOLD && !fifo_clear)
    |=> tx_err_q)
    else $error("error flag lost while locked");
  a_dir_level: assert property (@(posedge mclk)
    disable iff (!rst_b) $rose(dir_active_q)
    |=> direction_pin == multidrop_q[5])
    else $error("direction level wrong");
  a_rx_echo: assert property (@(posedge mclk)
    disable iff (!rst_b) (half_q && tx_shifting) |=> rx_gated_data)
    else $error("own data echoed");
  a_rx_lock_idle: assert property (@(posedge mclk)
    disable iff (!rst_b) (half_q && !card_mode && tx_pending && !rx_busy)
    |=> rx_lock_q)
    else $error("receiver not locked");
  a_guard_min: assert property (@(posedge mclk)
    disable iff (!rst_b) (tx_shifting && tx_last_bit && t0_mode &&
    card_q[15:8] != GUARD_ONE_BIT) |=> guard_cnt_q >= NOMINAL_GUARD)
    else $error("guard time below two bits");
  c_retry: cover property (@(posedge mclk) disable iff (!rst_b) tx_retry);
  c_tx_err: cover property (@(posedge mclk) disable iff (!rst_b)
    $rose(tx_err_q));
  c_addr_hit: cover property (@(posedge mclk) disable iff (!rst_b)
    $rose(addr_seen_q));
  c_card_clk: cover property (@(posedge mclk) disable iff (!rst_b)
    $rose(card_clock_pin));
endmodule // usm_core

// File: test/usm_far_end.sv
// far-side model: smart card or rs-485 transceiver on the receive line
`timescale 1ns/1ps
module usm_far_end (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // requests from the bench
  input  wire logic talk,
  input  wire logic reject,
  // line side
  output logic      line,
  output logic      nack
);
  // bus pulled up to mark level whenever the far side is silent
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      line <= 1'b1;
      nack <= 1'b0;
    end else begin
      line <= !talk;
      nack <= reject;
    end
  end
endmodule // usm_far_end

// File: test/usm_core_test.sv
// self-checking bench for the serial mode control block
`timescale 1ns/1ps
module usm_core_test;
  import usm_pkg::*;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        bit_tick, tx_start, tx_last_bit, tx_pending, rx_busy;
  logic        rx_char_done, rx_char_bad, nack_seen, fifo_clear, rx_pin;
  logic [8:0]  rx_char;
  logic        tx_route, rx_route, dir_route, dir_pin, clk_route, clk_pin;
  logic        rx_gated, rx_accept, tx_lock, tx_retry, nack_send, par_irq;
  logic        talk, reject;
  logic [32:0] exp_q[$];
  int          error_cnt, n_tests, k, n, c;

  usm_core uut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_tick(bit_tick), .tx_start(tx_start), .tx_last_bit(tx_last_bit),
    .tx_pending(tx_pending), .rx_busy(rx_busy),
    .rx_char_done(rx_char_done), .rx_char(rx_char),
    .rx_char_bad(rx_char_bad), .nack_seen(nack_seen),
    .fifo_clear(fifo_clear), .serial_rx_pin(rx_pin),
    .serial_tx_route(tx_route), .serial_rx_route(rx_route),
    .direction_route(dir_route), .direction_pin(dir_pin),
    .card_clock_route(clk_route), .card_clock_pin(clk_pin),
    .rx_gated_data(rx_gated), .rx_accept(rx_accept), .tx_lock(tx_lock),
    .tx_retry(tx_retry), .nack_send(nack_send), .parity_irq(par_irq));
  usm_far_end far (.mclk(mclk), .rst_b(rst_b), .talk(talk),
    .reject(reject), .line(rx_pin), .nack(nack_seen));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // baud tick every fourth cycle
  always @(posedge mclk) begin
    k <= (k + 1) % 4;
    bit_tick <= (k == 3);
  end

  task chk(input logic [32:0] seen, input logic [32:0] want);
    n_tests++;
    if (seen !== want) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task close_out;
    $display("compares=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [32:0] want);
    int t;
    @(posedge mclk);
    exp_q.push_back(want);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    t = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && t < 20) begin
      t++;
      @(posedge mclk);
    end
    if (t == 20) begin
      error_cnt++;
      close_out;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read data and error code are taken at the completing edge
  always @(posedge mclk) begin
    if ($sampled(psel & penable & pready) === 1'b1) begin
      if (exp_q.size() == 0) chk(33'h1, 33'h0);
      else if ($sampled(pwrite)) chk({$sampled(pslverr), 32'h0},
                                     {exp_q.pop_front() & 33'h100000000});
      else chk({$sampled(pslverr), $sampled(prdata)},
               exp_q.pop_front());
    end
  end
  task wt(input int t);
    repeat (t) @(posedge mclk);
  endtask
  // counts pulses of one engine output over four cycles
  task cnt4(input int s);
    c = 0;
    repeat (4) begin
      wt(1);
      c += (s == 0) ? (rx_accept === 1'b1) : (s == 1) ? (par_irq === 1'b1)
         : (s == 2) ? (tx_retry === 1'b1) : (nack_send === 1'b1);
    end
  endtask
  task rx(input logic [8:0] b, input logic bad, input int s);
    @(posedge mclk);
    rx_char <= b; rx_char_bad <= bad; rx_char_done <= 1'b1;
    @(posedge mclk);
    rx_char_done <= 1'b0; rx_char_bad <= 1'b0;
    cnt4(s);
  endtask
  task pulse_nack;
    @(posedge mclk);
    reject <= 1'b1;
    @(posedge mclk);
    reject <= 1'b0;
    cnt4(2);
  endtask
  // one character through shifting and into its guard time
  task send_char;
    @(posedge mclk);
    tx_start <= 1'b1;
    @(posedge mclk);
    tx_start <= 1'b0;
    tx_last_bit <= 1'b1;
    @(posedge mclk);
    tx_last_bit <= 1'b0;
  endtask

  initial begin
    {psel, penable, pwrite, bit_tick, tx_start, tx_last_bit} = '0;
    {tx_pending, rx_busy, rx_char_done, rx_char_bad, fifo_clear} = '0;
    {talk, reject, paddr, pwdata, rx_char, k, rst_b} = '0;
    r = $urandom(32'h6ba7cbb0);
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    apb(0, ADDR_CONTROL, 0, {1'b0, CONTROL_RESET});
    apb(0, ADDR_HALF_DUP, 0, 33'h0);
    apb(0, ADDR_MULTIDROP, 0, 33'h0);
    apb(1, 12'h0fc, 32'hffffffff, 33'h100000000);
    apb(0, 12'h0fc, 0, 33'h100000000);
    r = $urandom;
    apb(1, ADDR_MATCH, r, 33'h0);
    apb(0, ADDR_MATCH, 0, {25'h0, r[7:0]});
    chk({tx_route, rx_route, clk_route, dir_route}, 33'h0);
    apb(1, ADDR_CONTROL, {28'hc, MODE_RS485, 1'b1}, 33'h0);
    wt(2);
    chk({tx_route, rx_route, clk_route}, 33'h6);
    $display("reset, map and routing done");
    apb(1, ADDR_DELAY, 32'h2, 33'h0);
    for (int i = 0; i < 2; i++) begin
      apb(1, ADDR_MULTIDROP, {26'h0, i[0], 5'h10}, 33'h0);
      wt(2);
      chk({dir_route, dir_pin}, {1'b1, !i[0]});
      tx_pending <= 1'b1;
      wt(3);
      chk(dir_pin, i[0]);
      tx_last_bit <= 1'b1; tx_pending <= 1'b0;
      wt(1);
      tx_last_bit <= 1'b0;
      wt(2);
      chk(dir_pin, i[0]);
      wt(14);
      chk(dir_pin, !i[0]);
    end
    $display("direction control done");
    for (int i = 0; i < 2; i++) begin
      apb(1, ADDR_MULTIDROP, {30'h0, i[0], 1'b1}, 33'h0);
      rx({1'b0, r[7:0]}, 1'b0, 0);
      chk(c, i);
    end
    rx({1'b1, r[7:0]}, 1'b0, 1);
    chk(c, 1);
    apb(0, ADDR_STATUS, 0, 33'h2);
    apb(1, ADDR_STATUS, 32'h2, 33'h0);
    apb(0, ADDR_STATUS, 0, 33'h0);
    apb(1, ADDR_MULTIDROP, 32'h7, 33'h0);
    rx(9'h03c, 1'b0, 0);
    chk(c, 0);
    rx({1'b1, ~r[7:0]}, 1'b0, 0);
    rx(9'h03c, 1'b0, 0);
    chk(c, 0);
    rx({1'b1, r[7:0]}, 1'b0, 0);
    rx(9'h03c, 1'b0, 0);
    chk(c, 1);
    $display("multidrop done");
    // card mode: clock divider, nack retries and error lock, nack suppression
    apb(1, ADDR_CONTROL, {28'hc, MODE_CARD, 1'b1}, 33'h0);
    for (int i = 0; i < 3; i += 2) begin
      apb(1, ADDR_CARD_CTRL, {8'h0, i[7:0], 16'h0028}, 33'h0);
      wt(2);
      chk(clk_route, 1);
      n = 0;
      c = 0;
      r[0] = clk_pin;
      while (clk_pin === r[0] && c < 20) begin wt(1); c++; end
      r[0] = clk_pin;
      while (clk_pin === r[0] && n < 20) begin wt(1); n++; end
      chk(n, i + 1);
    end
    send_char();
    pulse_nack();
    chk({c[0], tx_lock}, 33'h2);
    send_char();
    pulse_nack();
    chk(c, 0);
    chk(tx_lock, 1);
    fifo_clear <= 1'b1;
    wt(1);
    fifo_clear <= 1'b0;
    wt(3);
    chk(tx_lock, 0);
    for (int i = 0; i < 3; i++) begin
      apb(1, ADDR_CARD_CTRL, {24'h000200, 5'h1, i == 2, i == 1, 1'b0}, 0);
      rx(9'h055, 1'b1, 3);
      chk(c, i == 0);
    end
    $display("card interface done");
    apb(1, ADDR_CONTROL, {28'hc, MODE_RS485, 1'b1}, 33'h0);
    // half duplex changed only while the line is idle
    apb(1, ADDR_HALF_DUP, 32'h1, 33'h0);
    tx_start <= 1'b1;
    tx_pending <= 1'b1;
    talk <= 1'b1;
    wt(1);
    tx_start <= 1'b0;
    wt(6);
    chk(rx_gated, 1);
    chk(tx_lock, 1);
    tx_last_bit <= 1'b1;
    tx_pending <= 1'b0;
    wt(1);
    tx_last_bit <= 1'b0;
    wt(6);
    chk(rx_gated, 0);
    chk(tx_lock, 0);
    talk <= 1'b0;
    $display("half duplex done");
    close_out;
  end
endmodule // usm_core_test
